// *** include/six_switch_pkg.sv ***
package six_switch_pkg;

	// ***************************************************
	// Sizes and frame layout
	// ***************************************************
	localparam int NUM_CH = 6;
	localparam int FRAME_SHORT = 8;
	localparam int FRAME_LONG = 16;
	localparam int FAULT_BITS = 8;
	localparam int CNT_BITS_W = 5;
	localparam int OVER_TEMP_POS = 6;

	// ***************************************************
	// Reset values
	// ***************************************************
	localparam logic [NUM_CH-1:0] CTRL_RST = 6'h00;
	localparam logic [FAULT_BITS-1:0] FAULT_RST = 8'h00;
	localparam logic [FRAME_LONG-1:0] SHIFT_RST = 16'h0000;

	// ***************************************************
	// Timing, figures in microseconds, then clock cycles
	// ***************************************************
	localparam int CLK_MHZ = 100;
	localparam int ARM_DELAY_US = 70;
	localparam int OPEN_DELAY_US = 70;
	localparam int SENSE_PERIOD_US = 4000;
	localparam int SENSE_PULSE_US = 70;
	localparam int ARM_DELAY_CYC = ARM_DELAY_US * CLK_MHZ;
	localparam int OPEN_DELAY_CYC = OPEN_DELAY_US * CLK_MHZ;
	localparam int SENSE_PERIOD_CYC = SENSE_PERIOD_US * CLK_MHZ;
	localparam int SENSE_PULSE_CYC = SENSE_PULSE_US * CLK_MHZ;

	// ***************************************************
	// Carriers
	// ***************************************************
	// Serial link pins as sampled
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic sdi;
	} link_t;

	// Analog comparator levels from the power stage
	typedef struct packed {
		logic over_volt;
		logic over_temp;
		logic [NUM_CH-1:0] over_cur;
		logic [NUM_CH-1:0] drain_low;
	} sense_t;

	// Fault word as shifted out, most significant bit first
	typedef struct packed {
		logic spare;
		logic over_temp;
		logic [NUM_CH-1:0] chan;
	} fault_word_t;

endpackage

// *** rtl/chan_protect.sv ***
`timescale 1ns/100ps
module chan_protect #(
	parameter int ARM_CYC = six_switch_pkg::ARM_DELAY_CYC,
	parameter int OPEN_CYC = six_switch_pkg::OPEN_DELAY_CYC,
	parameter int PERIOD_CYC = six_switch_pkg::SENSE_PERIOD_CYC,
	parameter int PULSE_CYC = six_switch_pkg::SENSE_PULSE_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Command and protection inputs, already synchronised
	input wire logic cmd_on_i,
	input wire logic force_off_i,
	input wire logic over_cur_i,
	input wire logic drain_low_i,
	// Gate drive and fault flag
	output logic gate_o,
	output logic fault_o
);
	import six_switch_pkg::*;

	localparam int CW = $clog2(PERIOD_CYC + 1);
	localparam logic [CW-1:0] ARM_LAST = CW'(ARM_CYC - 1);
	localparam logic [CW-1:0] OPEN_DONE = CW'(OPEN_CYC);
	localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);
	localparam logic [CW-1:0] DARK_LAST = CW'(PERIOD_CYC - PULSE_CYC - 1);

	typedef enum logic [2:0] {ST_OFF, ST_ARM, ST_ON, ST_PWM_OFF, ST_PWM_ON} chan_state_t;

	chan_state_t state_r;
	logic [CW-1:0] cnt_r;
	logic gate_r;
	logic open_r;
	logic fault_r;
	logic want_on;

	// Commanded on and not locked out by battery over-voltage
	assign want_on = cmd_on_i & ~force_off_i;

	// Channel sequence: arm delay, normal on, low duty sense cycling
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_r <= ST_OFF;
			cnt_r <= '0;
		end else if (!want_on) begin
			if (state_r != ST_OFF) begin
				state_r <= ST_OFF;
				cnt_r <= '0;
			end else if (cnt_r != OPEN_DONE) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end else begin
			unique case (state_r)
				ST_OFF: begin
					state_r <= ST_ARM;
					cnt_r <= '0;
				end
				ST_ARM: begin
					if (cnt_r == ARM_LAST) begin
						state_r <= ST_ON;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_ON: begin
					if (over_cur_i) begin
						state_r <= ST_PWM_OFF;
						cnt_r <= '0;
					end
				end
				ST_PWM_OFF: begin
					if (cnt_r == DARK_LAST) begin
						state_r <= ST_PWM_ON;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				ST_PWM_ON: begin
					if (cnt_r == PULSE_LAST) begin
						state_r <= over_cur_i ? ST_PWM_OFF : ST_ON;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
			endcase
		end
	end

	// Gate follows the state, cut at once when the command drops
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			gate_r <= 1'b0;
		end else begin
			gate_r <= want_on & (state_r == ST_ARM || state_r == ST_ON
				|| state_r == ST_PWM_ON);
		end
	end

	// Open-load test once the drain has settled after turn-off
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			open_r <= 1'b0;
		end else if (want_on) begin
			open_r <= 1'b0;
		end else if (state_r == ST_OFF && cnt_r == OPEN_DONE) begin
			open_r <= drain_low_i;
		end
	end

	// Channel fault: shorted load cycling or open load
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= open_r | state_r == ST_PWM_OFF | state_r == ST_PWM_ON;
		end
	end

	assign gate_o = gate_r;
	assign fault_o = fault_r;

	// ***************************************************
	// Checks
	// ***************************************************
	property p_ovl_off;
		@(posedge clock_i) disable iff (srst_i)
		force_off_i |=> !gate_r;
	endproperty
	a_ovl_off: assert property (p_ovl_off)
		else $error("gate on during over-voltage");

	property p_arm_guard;
		@(posedge clock_i) disable iff (srst_i)
		state_r == ST_ARM |=> state_r != ST_PWM_OFF;
	endproperty
	a_arm_guard: assert property (p_arm_guard)
		else $error("protection entered before arm delay");

	property p_pwm_enter;
		@(posedge clock_i) disable iff (srst_i)
		state_r == ST_ON && over_cur_i && want_on |=> state_r == ST_PWM_OFF ##1 !gate_r;
	endproperty
	a_pwm_enter: assert property (p_pwm_enter)
		else $error("over-current did not start low duty mode");

	property p_pulse_len;
		@(posedge clock_i) disable iff (srst_i)
		state_r == ST_PWM_ON |-> cnt_r <= PULSE_LAST;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("sense pulse too long");

	property p_recover;
		@(posedge clock_i) disable iff (srst_i)
		state_r == ST_PWM_ON && cnt_r == PULSE_LAST && !over_cur_i && want_on
			|=> state_r == ST_ON;
	endproperty
	a_recover: assert property (p_recover)
		else $error("channel did not return to normal");

endmodule

// *** rtl/six_switch_ctrl.sv ***
`timescale 1ns/100ps
module six_switch_ctrl #(
	parameter int ARM_CYC = six_switch_pkg::ARM_DELAY_CYC,
	parameter int OPEN_CYC = six_switch_pkg::OPEN_DELAY_CYC,
	parameter int PERIOD_CYC = six_switch_pkg::SENSE_PERIOD_CYC,
	parameter int PULSE_CYC = six_switch_pkg::SENSE_PULSE_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// Serial link
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// Power stage comparators
	input wire logic [six_switch_pkg::NUM_CH-1:0] over_cur_i,
	input wire logic [six_switch_pkg::NUM_CH-1:0] drain_low_i,
	input wire logic over_temp_i,
	input wire logic over_volt_i,
	// Channel gate drives
	output logic output_channel_0_o,
	output logic output_channel_1_o,
	output logic output_channel_2_o,
	output logic output_channel_3_o,
	output logic output_channel_4_o,
	output logic output_channel_5_o,
	// Status
	output logic [six_switch_pkg::NUM_CH-1:0] ctrl_o,
	output six_switch_pkg::fault_word_t fault_word_o,
	output logic frame_err_o
);
	import six_switch_pkg::*;

	localparam logic [CNT_BITS_W-1:0] FAULT_LEN = CNT_BITS_W'(FAULT_BITS);
	localparam logic [CNT_BITS_W-1:0] LEN_SHORT = CNT_BITS_W'(FRAME_SHORT);
	localparam logic [CNT_BITS_W-1:0] LEN_LONG = CNT_BITS_W'(FRAME_LONG);
	localparam logic [CNT_BITS_W-1:0] CNT_MAX = '1;

	// ***************************************************
	// Input synchronisers
	// ***************************************************
	link_t link_s1_r;
	link_t link_s2_r;
	link_t link_d_r;
	sense_t sense_s1_r;
	sense_t sense_s2_r;

	// Two stages for every pin from outside the clock domain
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			link_s1_r <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			link_s2_r <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
			sense_s1_r <= '0;
			sense_s2_r <= '0;
		end else begin
			link_s1_r <= '{sclk: sclk_i, cs_n: cs_n_i, sdi: sdi_i};
			link_s2_r <= link_s1_r;
			sense_s1_r <= '{over_volt: over_volt_i, over_temp: over_temp_i,
				over_cur: over_cur_i, drain_low: drain_low_i};
			sense_s2_r <= sense_s1_r;
		end
	end

	// Delayed copy of the settled link for edge finding
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			link_d_r <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
		end else begin
			link_d_r <= link_s2_r;
		end
	end

	// ***************************************************
	// Link edges
	// ***************************************************
	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic shift_en;

	// Edges seen on the settled samples
	assign cs_low = ~link_s2_r.cs_n;
	assign cs_fall = ~link_s2_r.cs_n & link_d_r.cs_n;
	assign cs_rise = link_s2_r.cs_n & ~link_d_r.cs_n;
	assign sclk_rise = link_s2_r.sclk & ~link_d_r.sclk;
	assign shift_en = sclk_rise & cs_low & ~cs_fall;

	// ***************************************************
	// Serial shift path
	// ***************************************************
	logic [FRAME_LONG-1:0] in_sh_r;
	logic [FAULT_BITS-1:0] out_sh_r;
	logic [CNT_BITS_W-1:0] bit_cnt_r;
	logic sdo_r;
	logic sdo_oe_r;
	fault_word_t fault_now;
	logic [NUM_CH-1:0] chan_fault_w;
	logic [NUM_CH-1:0] gate_w;

	// Live fault picture for the snapshot
	assign fault_now = '{spare: 1'b0, over_temp: sense_s2_r.over_temp,
		chan: chan_fault_w};

	// Input bits enter at the bottom so the first bit ends on top
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			in_sh_r <= SHIFT_RST;
		end else if (shift_en) begin
			in_sh_r <= {in_sh_r[FRAME_LONG-2:0], link_s2_r.sdi};
		end
	end

	// Bits taken since the frame opened, stuck at the top
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			bit_cnt_r <= '0;
		end else if (cs_fall) begin
			bit_cnt_r <= '0;
		end else if (shift_en && bit_cnt_r != CNT_MAX) begin
			bit_cnt_r <= bit_cnt_r + 1'b1;
		end
	end

	// Fault word loaded at frame open, shifted out mixed into the first eight data bits
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			out_sh_r <= FAULT_RST;
		end else if (cs_fall) begin
			out_sh_r <= fault_now;
		end else if (shift_en) begin
			out_sh_r <= {out_sh_r[FAULT_BITS-2:0], 1'b0};
		end
	end

	// Output bit is the fault bit mixed with the bit just taken for the first eight bits, then the bit alone
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sdo_r <= 1'b0;
		end else if (cs_fall) begin
			sdo_r <= 1'b0;
		end else if (shift_en) begin
			if (bit_cnt_r < FAULT_LEN) begin
				sdo_r <= out_sh_r[FAULT_BITS-1] ^ link_s2_r.sdi;
			end else begin
				sdo_r <= link_s2_r.sdi;
			end
		end
	end

	// Output driven only inside the frame
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sdo_oe_r <= 1'b0;
		end else begin
			sdo_oe_r <= cs_low;
		end
	end

	// ***************************************************
	// Frame close
	// ***************************************************
	logic [NUM_CH-1:0] ctrl_r;
	fault_word_t fault_snap_r;
	logic frame_err_r;

	// Last six bits become the channel commands at frame close
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ctrl_r <= CTRL_RST;
		end else if (cs_rise) begin
			ctrl_r <= in_sh_r[NUM_CH-1:0];
		end
	end

	// Copy of the fault word taken at frame open, for status
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fault_snap_r <= FAULT_RST;
		end else if (cs_fall) begin
			fault_snap_r <= fault_now;
		end
	end

	// Frame length other than eight or sixteen bits
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			frame_err_r <= 1'b0;
		end else if (cs_rise) begin
			frame_err_r <= bit_cnt_r != LEN_SHORT && bit_cnt_r != LEN_LONG;
		end
	end

	// ***************************************************
	// Channel protection
	// ***************************************************
	// One independent protection block per channel
	for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
		chan_protect #(
			.ARM_CYC(ARM_CYC),
			.OPEN_CYC(OPEN_CYC),
			.PERIOD_CYC(PERIOD_CYC),
			.PULSE_CYC(PULSE_CYC)
		) u_chan (
			.clock_i(clock_i),
			.srst_i(srst_i),
			.cmd_on_i(ctrl_r[i]),
			.force_off_i(sense_s2_r.over_volt),
			.over_cur_i(sense_s2_r.over_cur[i]),
			.drain_low_i(sense_s2_r.drain_low[i]),
			.gate_o(gate_w[i]),
			.fault_o(chan_fault_w[i])
		);
	end

	// Outputs, each straight from a flip-flop
	assign output_channel_0_o = gate_w[0];
	assign output_channel_1_o = gate_w[1];
	assign output_channel_2_o = gate_w[2];
	assign output_channel_3_o = gate_w[3];
	assign output_channel_4_o = gate_w[4];
	assign output_channel_5_o = gate_w[5];
	assign sdo_o = sdo_r;
	assign sdo_oe_o = sdo_oe_r;
	assign ctrl_o = ctrl_r;
	assign fault_word_o = fault_snap_r;
	assign frame_err_o = frame_err_r;

	// ***************************************************
	// Checks
	// ***************************************************
	property p_msb_first;
		@(posedge clock_i) disable iff (srst_i)
		shift_en |=> in_sh_r == {$past(in_sh_r[FRAME_LONG-2:0]), $past(link_s2_r.sdi)};
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("input bit not shifted in at bottom");

	property p_latch;
		@(posedge clock_i) disable iff (srst_i)
		cs_rise |=> ctrl_r == $past(in_sh_r[NUM_CH-1:0]);
	endproperty
	a_latch: assert property (p_latch)
		else $error("control latch missed frame close");

	property p_hold;
		@(posedge clock_i) disable iff (srst_i)
		!cs_rise |=> $stable(ctrl_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("control latch moved outside frame close");

	property p_snapshot;
		@(posedge clock_i) disable iff (srst_i)
		cs_fall |=> fault_snap_r == $past(fault_now) && out_sh_r == $past(fault_now);
	endproperty
	a_snapshot: assert property (p_snapshot)
		else $error("fault snapshot wrong at frame open");

	property p_xor;
		@(posedge clock_i) disable iff (srst_i)
		shift_en && bit_cnt_r < FAULT_LEN
			|=> sdo_r == ($past(out_sh_r[FAULT_BITS-1]) ^ $past(link_s2_r.sdi));
	endproperty
	a_xor: assert property (p_xor)
		else $error("output bit not fault xor input");

	property p_sdo_edge;
		@(posedge clock_i) disable iff (srst_i)
		!shift_en && !cs_fall |=> $stable(sdo_r);
	endproperty
	a_sdo_edge: assert property (p_sdo_edge)
		else $error("output bit changed off the clock edge");

	property p_release;
		@(posedge clock_i) disable iff (srst_i)
		cs_rise |=> !sdo_oe_r ##1 !sdo_oe_r;
	endproperty
	a_release: assert property (p_release)
		else $error("output still driven after frame close");

	property p_temp_pos;
		@(posedge clock_i) disable iff (srst_i)
		cs_fall |=> out_sh_r[OVER_TEMP_POS] == $past(sense_s2_r.over_temp);
	endproperty
	a_temp_pos: assert property (p_temp_pos)
		else $error("over-temperature flag misplaced");

endmodule

// *** verification/spi_master_model.sv ***
`timescale 1ns/100ps
// ************************************************
// Serial link master on the far side of the switch
// ************************************************
module spi_master_model (
	// Clock
	input wire logic clock_i,
	// Link pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	// Link idles with clock low and select high
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	// One frame of n bits; SCLK period 16 clocks, received bits in q
	task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q);
		q = 16'h0000;
		@(posedge clock_i);
		cs_n_o <= 1'b0;
		repeat (8) @(posedge clock_i);
		for (int k = 0; k < n; k++) begin
			sdi_o <= d[n-1-k];
			repeat (8) @(posedge clock_i);
			sclk_o <= 1'b1;
			repeat (8) @(posedge clock_i);
			q[n-1-k] = sdo_i;
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge clock_i);
		// Select rises only once every bit is shifted
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o; // Released line shows no stale value
		repeat (8) @(posedge clock_i);
	endtask
endmodule

// *** verification/serial_six_channel_switch_ctrl_tb.sv ***
`timescale 1ns/100ps
// ************************************************
// Testbench for the six channel switch controller
// ************************************************
module serial_six_channel_switch_ctrl_tb;
	import six_switch_pkg::*;
	localparam int ARM = 20;
	localparam int OPEN = 20;
	localparam int PERIOD = 200;
	localparam int PULSE = 20;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic sclk, cs_n, sdi, sdo, sdo_oe, sdo_line;
	logic sdo_last = 1'b0;
	logic [NUM_CH-1:0] over_cur = 6'h00;
	logic [NUM_CH-1:0] drain_low = 6'h00;
	logic over_temp = 1'b0;
	logic over_volt = 1'b0;
	logic [NUM_CH-1:0] ctrl, gates;
	logic g0, g1, g2, g3, g4, g5, frame_err;
	fault_word_t fault_word;
	int failures = 0;
	int compares = 0;
	int seed = 22462;

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	six_switch_ctrl #(.ARM_CYC(ARM), .OPEN_CYC(OPEN), .PERIOD_CYC(PERIOD), .PULSE_CYC(PULSE)) DUT (
		.clock_i(clock_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .over_cur_i(over_cur), .drain_low_i(drain_low),
		.over_temp_i(over_temp), .over_volt_i(over_volt), .output_channel_0_o(g0),
		.output_channel_1_o(g1), .output_channel_2_o(g2), .output_channel_3_o(g3),
		.output_channel_4_o(g4), .output_channel_5_o(g5), .ctrl_o(ctrl),
		.fault_word_o(fault_word), .frame_err_o(frame_err)
	);

	spi_master_model m (.clock_i(clock_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
		.sdo_i(sdo_line));

	// Undriven data out shows the inverse of its last value
	assign gates = {g5, g4, g3, g2, g1, g0};
	assign sdo_line = sdo_oe ? sdo : ~sdo_last;
	always @(posedge clock_i) begin
		if (sdo_oe) sdo_last <= sdo;
	end

	// ************************************************
	// Compare and report tasks
	// ************************************************
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chk_six(input logic [5:0] got, input logic [5:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t six got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_word(input fault_word_t got, input fault_word_t exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t fault got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// One frame against the bench model of the returned bits
	task automatic frame(input int n, input logic [5:0] c, input logic [5:0] chan);
		logic [15:0] d;
		logic [15:0] q;
		fault_word_t fx;
		logic e[$];
		d = {10'h000, c};
		fx = {1'b0, over_temp, chan};
		for (int k = 0; k < n; k++) e.push_back(k < FAULT_BITS ? fx[7-k] ^ d[n-1-k] : d[n-1-k]);
		m.xfer(n, d, q);
		for (int k = 0; k < n; k++) chk_bit(q[n-1-k], e.pop_front());
		chk_word(fault_word, fx);
		chk_six(ctrl, c);
		chk_bit(frame_err, n != 8 && n != 16);
		chk_bit(sdo_oe, 1'b0);
	endtask

	// Cycles until channel 1 gate reaches a level, bounded
	task automatic wait_g1(input logic lvl, output int n);
		n = 0;
		while (g1 !== lvl && n < 400) begin
			@(posedge clock_i);
			n++;
		end
	endtask

	// Watchdog sized well above the expected run
	initial begin
		repeat (60000) @(posedge clock_i);
		failures++;
		tally_and_finish;
	end

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		logic [5:0] c;
		int n;
		repeat (5) @(posedge clock_i);
		srst_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		chk_six(ctrl, CTRL_RST);
		chk_six(gates, 6'h00);
		chk_word(fault_word, FAULT_RST);
		$display("test reset done");
		// Random commands in both frame lengths
		for (int i = 0; i < 6; i++) begin
			c = 6'($random(seed));
			over_temp <= 1'($random(seed));
			@(posedge clock_i);
			frame((i % 2) ? 16 : 8, c, 6'h00);
			chk_six(gates, c);
		end
		frame(12, 6'h2A, 6'h00);
		$display("test frames done");
		// Open load while off, then arming delay and low duty mode
		over_temp <= 1'b0;
		// Let the cleared flag settle before the model reads it
		@(posedge clock_i);
		frame(8, 6'h00, 6'h00);
		drain_low <= 6'h05;
		over_cur <= 6'h02;
		repeat (OPEN + 20) @(posedge clock_i);
		frame(16, 6'h3F, 6'h05);
		chk_six(gates, 6'h3F);
		drain_low <= 6'h00;
		repeat (ARM + 10) @(posedge clock_i);
		chk_six(gates, 6'h3D);
		frame(8, 6'h3F, 6'h02);
		wait_g1(1'b1, n);
		wait_g1(1'b0, n);
		chk_bit(n >= PULSE - 1 && n <= PULSE + 1, 1'b1);
		wait_g1(1'b1, n);
		chk_bit(n >= PERIOD - PULSE - 1 && n <= PERIOD - PULSE + 1, 1'b1);
		over_cur <= 6'h00;
		repeat (PERIOD + 50) @(posedge clock_i);
		chk_six(gates, 6'h3F);
		frame(8, 6'h3F, 6'h00);
		$display("test protection done");
		// Over-voltage forces all off, then recovers
		over_volt <= 1'b1;
		repeat (10) @(posedge clock_i);
		chk_six(gates, 6'h00);
		chk_six(ctrl, 6'h3F);
		over_volt <= 1'b0;
		repeat (ARM + 10) @(posedge clock_i);
		chk_six(gates, 6'h3F);
		$display("test over-voltage done");
		// Reset in mid-run
		srst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		srst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		chk_six(ctrl, CTRL_RST);
		chk_six(gates, 6'h00);
		chk_bit(sdo_oe, 1'b0);
		$display("test second reset done");
		tally_and_finish;
	end
endmodule
